// ===== core/fsr_pkg.sv
// Functional notes
// - Two-byte status register with busy and protection
// - Status read accepted even while busy
// - After opcode, one status bit per clock
// - Byte pair repeats while select held
// - Each repetition samples live status
// - Ready/busy in both bytes, refreshed per byte
// - Above limit host reads four bytes
// - Select deassert ends read, output released
// - First bit 7 lock flag, resets 0
// - Reserved bits read as zero
// - First bit 5 read-only error flag
// - First bit 4 mirrors protect pin level
// - First bits 3:2 software protection field
// - First bit 1 write enable latch
// - Bit 0 of each byte ready/busy
// - First-byte write changes bit 7 only
// - Second bit 4 reset command enable
// - Second bit 3 lockdown enable
// - Second bit 2 program suspend flag
// - Second bit 1 erase suspend flag
// - Second-byte write changes bits 4,3 only
// - Protect pin held: lock only 0 to 1
package fsr_pkg;
  localparam logic [7:0] OPC_READ_STATUS = 8'h05;
  localparam logic [7:0] OPC_WRITE_FIRST = 8'h01;
  localparam logic [7:0] OPC_WRITE_SECOND = 8'h31;
  localparam int FIRST_LOCK_BIT = 7;
  localparam int FIRST_RSVD_BIT = 6;
  localparam int FIRST_ERROR_BIT = 5;
  localparam int FIRST_PIN_BIT = 4;
  localparam int FIRST_SOFT_PROT_LSB = 2;
  localparam int FIRST_WR_EN_BIT = 1;
  localparam int BUSY_BIT = 0;
  localparam int SECOND_RSVD_LSB = 5;
  localparam int SECOND_RST_EN_BIT = 4;
  localparam int SECOND_LOCKDOWN_BIT = 3;
  localparam int SECOND_PROG_SUSP_BIT = 2;
  localparam int SECOND_ERASE_SUSP_BIT = 1;
  localparam logic LOCK_RESET = 1'b0;
  localparam logic RST_EN_RESET = 1'b0;
  localparam logic LOCKDOWN_RESET = 1'b0;
  localparam int SYNC_STAGES = 2;
endpackage : fsr_pkg

// ===== core/fsr_status_read.sv
`timescale 1ns/100ps
module fsr_status_read (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic SI,
  input wire logic WP_N,
  output logic SO_OUT,
  output logic SO_OE,
  input wire logic BUSY,
  input wire logic ERROR_FLAG,
  input wire logic [1:0] SOFT_PROTECT,
  input wire logic WRITE_ENABLE,
  input wire logic PROG_SUSPEND,
  input wire logic ERASE_SUSPEND,
  output logic PROTECTION_LOCK,
  output logic RESET_CMD_ENABLE,
  output logic LOCKDOWN_ENABLE
);
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_STATUS,
    ST_WR_FIRST,
    ST_WR_SECOND,
    ST_IGNORE
  } fsr_state_e;

  logic [3:0] pins_s;
  logic sck_s;
  logic cs_n_s;
  logic si_s;
  logic wp_n_s;
  logic sck_d;
  logic sck_rise;
  logic sck_fall;

  fsr_sync #(
    .WIDTH(4),
    // Clock high, deselected, protect pin released: no frame before pins settle
    .INIT(4'hd)
  ) u_sync (
    .CLK(CLK),
    .RESETN(RESETN),
    .D({SCK, CS_N, SI, WP_N}),
    .Q(pins_s)
  );

  assign sck_s = pins_s[3];
  assign cs_n_s = pins_s[2];
  assign si_s = pins_s[1];
  assign wp_n_s = pins_s[0];
  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;

  fsr_state_e state;
  fsr_state_e next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] in_shift;
  logic [7:0] next_in_shift;
  logic [2:0] out_idx;
  logic [2:0] next_out_idx;
  logic byte_sel;
  logic next_byte_sel;
  logic [7:0] out_hold;
  logic [7:0] next_out_hold;
  logic so;
  logic next_so;
  logic oe;
  logic next_oe;
  logic prot_lock;
  logic next_prot_lock;
  logic reset_en;
  logic next_reset_en;
  logic lock_en;
  logic next_lock_en;
  logic [7:0] first_byte;
  logic [7:0] second_byte;
  logic [7:0] rx_byte;
  logic [7:0] live_byte;

  // Live status assembly, no snapshot held between bytes
  always_comb begin
    first_byte = 8'h00;
    first_byte[fsr_pkg::FIRST_LOCK_BIT] = prot_lock;
    first_byte[fsr_pkg::FIRST_ERROR_BIT] = ERROR_FLAG;
    first_byte[fsr_pkg::FIRST_PIN_BIT] = wp_n_s;
    first_byte[fsr_pkg::FIRST_SOFT_PROT_LSB +: 2] = SOFT_PROTECT;
    first_byte[fsr_pkg::FIRST_WR_EN_BIT] = WRITE_ENABLE;
    first_byte[fsr_pkg::BUSY_BIT] = BUSY;
    second_byte = 8'h00;
    second_byte[fsr_pkg::SECOND_RST_EN_BIT] = reset_en;
    second_byte[fsr_pkg::SECOND_LOCKDOWN_BIT] = lock_en;
    second_byte[fsr_pkg::SECOND_PROG_SUSP_BIT] = PROG_SUSPEND;
    second_byte[fsr_pkg::SECOND_ERASE_SUSP_BIT] = ERASE_SUSPEND;
    second_byte[fsr_pkg::BUSY_BIT] = BUSY;
  end

  assign rx_byte = {in_shift[6:0], si_s};
  assign live_byte = byte_sel ? second_byte : first_byte;

  always_comb begin
    next_state = state;
    next_bit_cnt = bit_cnt;
    next_in_shift = in_shift;
    next_out_idx = out_idx;
    next_byte_sel = byte_sel;
    next_out_hold = out_hold;
    next_so = so;
    next_oe = oe;
    next_prot_lock = prot_lock;
    next_reset_en = reset_en;
    next_lock_en = lock_en;
    if (cs_n_s) begin
      // Abort at any bit position and release the line
      next_state = ST_OPCODE;
      next_bit_cnt = 3'd0;
      next_out_idx = 3'd0;
      next_byte_sel = 1'b0;
      next_oe = 1'b0;
      next_so = 1'b0;
    end else begin
      case (state)
        ST_OPCODE: begin
          if (sck_rise) begin
            next_in_shift = rx_byte;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              // Busy does not gate the read opcode
              if (rx_byte == fsr_pkg::OPC_READ_STATUS) begin
                next_state = ST_STATUS;
              end else if (rx_byte == fsr_pkg::OPC_WRITE_FIRST) begin
                next_state = ST_WR_FIRST;
              end else if (rx_byte == fsr_pkg::OPC_WRITE_SECOND) begin
                next_state = ST_WR_SECOND;
              end else begin
                next_state = ST_IGNORE;
              end
            end
          end
        end
        ST_STATUS: begin
          if (sck_fall) begin
            next_oe = 1'b1;
            next_out_idx = out_idx + 3'd1;
            if (out_idx == 3'd0) begin
              // Fresh capture at each byte start keeps the byte coherent
              next_out_hold = live_byte;
              next_so = live_byte[7];
            end else begin
              next_so = out_hold[3'd7 - out_idx];
            end
            if (out_idx == 3'd7) begin
              // Valid from the first byte, so a four-byte read also holds
              next_byte_sel = !byte_sel;
            end
          end
        end
        ST_WR_FIRST: begin
          if (sck_rise) begin
            next_in_shift = rx_byte;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              next_state = ST_IGNORE;
              // Pin held low only allows locking
              if (WRITE_ENABLE && (wp_n_s || rx_byte[fsr_pkg::FIRST_LOCK_BIT])) begin
                next_prot_lock = rx_byte[fsr_pkg::FIRST_LOCK_BIT];
              end
            end
          end
        end
        ST_WR_SECOND: begin
          if (sck_rise) begin
            next_in_shift = rx_byte;
            next_bit_cnt = bit_cnt + 3'd1;
            if (bit_cnt == 3'd7) begin
              next_state = ST_IGNORE;
              if (WRITE_ENABLE) begin
                next_reset_en = rx_byte[fsr_pkg::SECOND_RST_EN_BIT];
                next_lock_en = rx_byte[fsr_pkg::SECOND_LOCKDOWN_BIT];
              end
            end
          end
        end
        default: begin
          next_state = ST_IGNORE;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      sck_d <= 1'b1;
      state <= ST_OPCODE;
      bit_cnt <= 3'd0;
      in_shift <= 8'h00;
      out_idx <= 3'd0;
      byte_sel <= 1'b0;
      out_hold <= 8'h00;
      so <= 1'b0;
      oe <= 1'b0;
      prot_lock <= fsr_pkg::LOCK_RESET;
      reset_en <= fsr_pkg::RST_EN_RESET;
      lock_en <= fsr_pkg::LOCKDOWN_RESET;
    end else begin
      sck_d <= sck_s;
      state <= next_state;
      bit_cnt <= next_bit_cnt;
      in_shift <= next_in_shift;
      out_idx <= next_out_idx;
      byte_sel <= next_byte_sel;
      out_hold <= next_out_hold;
      so <= next_so;
      oe <= next_oe;
      prot_lock <= next_prot_lock;
      reset_en <= next_reset_en;
      lock_en <= next_lock_en;
    end
  end

  assign SO_OUT = so;
  assign SO_OE = oe;
  assign PROTECTION_LOCK = prot_lock;
  assign RESET_CMD_ENABLE = reset_en;
  assign LOCKDOWN_ENABLE = lock_en;

  sequence seq_read_opcode;
    state == ST_OPCODE && !cs_n_s && sck_rise && bit_cnt == 3'd7
      && rx_byte == fsr_pkg::OPC_READ_STATUS;
  endsequence

  sequence seq_last_bit_out;
    state == ST_STATUS && !cs_n_s && sck_fall && out_idx == 3'd7;
  endsequence

  sequence seq_byte_capture;
    state == ST_STATUS && !cs_n_s && sck_fall && out_idx == 3'd0;
  endsequence

  a_read_enter: assert property (@(posedge CLK) disable iff (!RESETN)
    seq_read_opcode |=> state == ST_STATUS)
    else $error("read opcode did not start status output");

  a_first_bit_out: assert property (@(posedge CLK) disable iff (!RESETN)
    state == ST_STATUS && !cs_n_s && sck_fall && out_idx == 3'd0
      |=> SO_OE && SO_OUT == $past(live_byte[7]))
    else $error("first status bit not driven from live byte");

  a_pair_wrap: assert property (@(posedge CLK) disable iff (!RESETN)
    seq_last_bit_out |=> byte_sel != $past(byte_sel) && out_idx == 3'd0)
    else $error("status byte pair did not alternate");

  a_release_line: assert property (@(posedge CLK) disable iff (!RESETN)
    cs_n_s |=> !SO_OE ##1 !SO_OE)
    else $error("output still driven after deselect");

  a_rsvd_zero: assert property (@(posedge CLK) disable iff (!RESETN)
    seq_byte_capture |=> ($past(byte_sel) ? out_hold[7:fsr_pkg::SECOND_RSVD_LSB] == 3'h0
      : out_hold[fsr_pkg::FIRST_RSVD_BIT] == 1'b0))
    else $error("reserved status bit not zero");

  a_busy_both: assert property (@(posedge CLK) disable iff (!RESETN)
    seq_byte_capture |=> out_hold[fsr_pkg::BUSY_BIT] == $past(BUSY))
    else $error("busy flag not refreshed for a status byte");

  a_pin_mirror: assert property (@(posedge CLK) disable iff (!RESETN)
    seq_byte_capture ##0 !byte_sel |=> out_hold[fsr_pkg::FIRST_PIN_BIT] == $past(wp_n_s))
    else $error("pin status bit does not follow protect pin");

  a_lock_held: assert property (@(posedge CLK) disable iff (!RESETN)
    prot_lock && !wp_n_s |=> prot_lock)
    else $error("lock cleared while protect pin asserted");

  a_lock_source: assert property (@(posedge CLK) disable iff (!RESETN)
    $changed(prot_lock) |-> $past(state) == ST_WR_FIRST && $past(WRITE_ENABLE))
    else $error("lock changed outside first-byte write");

  a_second_source: assert property (@(posedge CLK) disable iff (!RESETN)
    $changed({reset_en, lock_en}) |-> $past(state) == ST_WR_SECOND && $past(WRITE_ENABLE))
    else $error("second-byte bits changed outside their write");
endmodule : fsr_status_read

// ===== core/fsr_sync.sv
`timescale 1ns/100ps
module fsr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      meta <= INIT;
      Q <= INIT;
    end else begin
      meta <= D;
      Q <= meta;
    end
  end
endmodule : fsr_sync

// ===== tb/fsr_host.sv
`timescale 1ns/100ps
module fsr_host (
  output logic SCK,
  output logic CS_N,
  output logic SI,
  input wire logic SO
);
  logic [7:0] rx;
  event got;
  initial begin
    SCK = 1'b0;
    CS_N = 1'b1;
    SI = 1'b0;
  end
  task automatic sel();
    CS_N = 1'b0;
    #100;
  endtask : sel
  task automatic desel();
    #40;
    CS_N = 1'b1;
    SI = ~SI; // Idle data line must not look like the last bit
    #100;
  endtask : desel
  // Mode 0, MSB first; sample at the rise, a partial byte is allowed
  task automatic shift(input logic [7:0] tx, input int nb, input bit tell);
    for (int i = 7; i > 7 - nb; i--) begin
      SI = tx[i];
      #62.5;
      SCK = 1'b1;
      rx[i] = SO;
      #62.5;
      SCK = 1'b0;
    end
    if (tell) ->got;
  endtask : shift
endmodule : fsr_host

// ===== tb/fsr_status_read_tb.sv
`timescale 1ns/100ps
module fsr_status_read_tb;
  logic CLK = 1'b0;
  logic RESETN = 1'b0;
  logic BUSY, ERROR_FLAG, WRITE_ENABLE, PROG_SUSPEND, ERASE_SUSPEND, WP_N;
  logic [1:0] SOFT_PROTECT;
  logic SCK, CS_N, SI, SO_OUT, SO_OE, PROTECTION_LOCK, RESET_CMD_ENABLE, LOCKDOWN_ENABLE;
  wire SO = SO_OE ? SO_OUT : 1'bz;
  logic lock = 1'b0;
  logic rst_en_exp = 1'b0;
  logic lkd_en_exp = 1'b0;
  logic [7:0] exp_q[$];
  int miscompares = 0;
  int comparisons = 0;
  always #5 CLK = ~CLK;
  fsr_host host (.SCK(SCK), .CS_N(CS_N), .SI(SI), .SO(SO));
  fsr_status_read DUT (.CLK(CLK), .RESETN(RESETN), .SCK(SCK), .CS_N(CS_N), .SI(SI),
    .WP_N(WP_N), .SO_OUT(SO_OUT), .SO_OE(SO_OE), .BUSY(BUSY), .ERROR_FLAG(ERROR_FLAG),
    .SOFT_PROTECT(SOFT_PROTECT), .WRITE_ENABLE(WRITE_ENABLE), .PROG_SUSPEND(PROG_SUSPEND),
    .ERASE_SUSPEND(ERASE_SUSPEND), .PROTECTION_LOCK(PROTECTION_LOCK),
    .RESET_CMD_ENABLE(RESET_CMD_ENABLE), .LOCKDOWN_ENABLE(LOCKDOWN_ENABLE));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic conclude();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // Expected status byte k from the live inputs as they stand now
  task automatic note(input int k);
    if (k[0])
      exp_q.push_back({3'h0, rst_en_exp, lkd_en_exp, PROG_SUSPEND, ERASE_SUSPEND,
        BUSY});
    else
      exp_q.push_back({lock, 1'b0, ERROR_FLAG, WP_N, SOFT_PROTECT, WRITE_ENABLE,
        BUSY});
  endtask : note
  // New live values for status byte k; only bytes that will be shifted get a note
  task automatic vary(input int k, input int n);
    @(posedge CLK) #1;
    {BUSY, ERROR_FLAG, SOFT_PROTECT, WRITE_ENABLE, PROG_SUSPEND, ERASE_SUSPEND, WP_N} =
      8'($urandom);
    if (k < n)
      note(k);
  endtask : vary
  task automatic rd(input int n, input int tail);
    vary(0, n);
    host.sel();
    host.shift(fsr_pkg::OPC_READ_STATUS, 8, 1'b0);
    for (int k = 0; k < n; k++) begin
      // Inputs move mid-byte, after this byte was captured
      fork
        host.shift(8'($urandom), 8, 1'b1);
        begin
          #500;
          vary(k + 1, n);
        end
      join
    end
    host.shift(8'h00, tail, 1'b0);
    host.desel();
    check({7'h0, SO_OE}, 8'h00);
    check({7'h0, SO}, {7'h0, 1'bz});
    $display("read of %0d bytes done", n);
  endtask : rd
  // Busy falls during the third byte; the host polls until it reads ready
  task automatic poll();
    int k;
    k = 0;
    @(posedge CLK) #1;
    BUSY = 1'b1;
    note(0);
    host.sel();
    host.shift(fsr_pkg::OPC_READ_STATUS, 8, 1'b0);
    while (k < 8 && (k == 0 || host.rx[0] !== 1'b0)) begin
      fork
        host.shift(8'($urandom), 8, 1'b1);
        begin
          #500;
          @(posedge CLK) #1;
          BUSY = (k < 2);
          note(k + 1);
        end
      join
      k++;
    end
    host.desel();
    check(8'(k), 8'h04);
    check(8'(exp_q.size()), 8'h01);
    exp_q.delete();
    $display("busy poll done");
  endtask : poll
  task automatic wr(input logic [7:0] opc, input logic [7:0] dat);
    host.sel();
    host.shift(opc, 8, 1'b0);
    host.shift(dat, 8, 1'b0);
    host.desel();
    if (WRITE_ENABLE && opc == fsr_pkg::OPC_WRITE_FIRST && (WP_N || dat[7]))
      lock = dat[7];
    if (WRITE_ENABLE && opc == fsr_pkg::OPC_WRITE_SECOND)
      {rst_en_exp, lkd_en_exp} = dat[4:3];
    check({5'h0, PROTECTION_LOCK, RESET_CMD_ENABLE, LOCKDOWN_ENABLE},
      {5'h0, lock, rst_en_exp, lkd_en_exp});
  endtask : wr
  always @(host.got)
    check(host.rx, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
  initial begin
    {BUSY, ERROR_FLAG, SOFT_PROTECT, WRITE_ENABLE, PROG_SUSPEND, ERASE_SUSPEND} = 7'h00;
    WP_N = 1'b1;
    void'($urandom(42338));
    repeat (2) @(posedge CLK);
    #1 RESETN = 1'b1;
    repeat (3) @(posedge CLK);
    #1;
    check({5'h0, PROTECTION_LOCK, RESET_CMD_ENABLE, LOCKDOWN_ENABLE}, 8'h00);
    $display("reset values done");
    rd(6, 0);
    rd(4, 3);
    host.sel();
    host.shift(8'h5a, 8, 1'b0);
    host.shift(8'h00, 8, 1'b0);
    check({7'h0, SO_OE}, 8'h00);
    host.desel();
    $display("unknown opcode done");
    for (int i = 0; i < 12; i++) begin
      @(posedge CLK) #1;
      WP_N = 1'($urandom);
      WRITE_ENABLE = ($urandom % 4) != 0;
      wr(i % 3 == 2 ? fsr_pkg::OPC_WRITE_SECOND : fsr_pkg::OPC_WRITE_FIRST, 8'($urandom));
    end
    $display("writes done");
    rd(5, 5);
    poll();
    conclude();
  end
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule : fsr_status_read_tb
